// [bench/dcsc_checker.sv]
// concurrent checks on the step and control block ports
module dcsc_checker (
  // clock, reset and apb
  input wire clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i, prdata_o,
  input wire [3:0] pstrb_i,
  // host bytes and core side
  input wire rx_valid_i, read_protect_i, brk_i, done_i, halt_o, sys_reset_o, stuff_o, exec_o,
  input wire [7:0] rx_data_i, stuff_opcode_o,
  input wire [2:0] stuff_fetch_o, exec_len_o,
  input wire [39:0] exec_bytes_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic brk_en_r;
  wire wr_ctrl = psel_i && penable_i && pwrite_i && pready_o && paddr_i == 8'h00 && pstrb_i[0];
  // tracks breakpoint enable as last written, reset clears it
  always_ff @(posedge clk_i) begin
    if (!nrst_i) brk_en_r <= 1'b0;
    else if (wr_ctrl) brk_en_r <= pwdata_i[6];
  end
  function automatic logic [2:0] oplen(input logic [7:0] o);
    if (o == 8'h00) return 3'h1;
    if (o == 8'h1F) return 3'h5;
    case (o[3:0])
      4'h0, 4'h1, 4'h2, 4'h3, 4'hA, 4'hB, 4'hC: return 3'h2;
      4'h4, 4'h5, 4'h6, 4'h7, 4'hD: return 3'h3;
      4'h8, 4'h9: return 3'h4;
      default: return 3'h1;
    endcase
  endfunction
  // ****************************************
  // assertions
  // ****************************************
  AST_STUFF: assert property (stuff_o |-> $past(rx_valid_i) && stuff_opcode_o == $past(rx_data_i))
    else $error("stuff pulse without its opcode byte");
  AST_FETCH: assert property (stuff_o |-> stuff_fetch_o == oplen(stuff_opcode_o) - 3'h1)
    else $error("stuff fetch count wrong");
  AST_STUFF_IGN: assert property (stuff_o |-> $past(halt_o, 2) && !$past(read_protect_i, 2))
    else $error("stuff ran outside debug state");
  AST_EXEC_LEN: assert property (exec_o |-> $past(rx_valid_i) && exec_len_o == oplen(exec_bytes_o[7:0]))
    else $error("exec length does not match opcode");
  AST_EXEC_REF: assert property (exec_o |-> halt_o && !$past(read_protect_i))
    else $error("exec ran outside debug state");
  AST_RST_PULSE: assert property ($rose(sys_reset_o) |-> sys_reset_o [*4] ##1 !sys_reset_o)
    else $error("reset pulse not four cycles");
  AST_HALT: assert property (wr_ctrl && pwdata_i[7:0] == 8'h81 |=> halt_o && sys_reset_o)
    else $error("reset and halt not taken");
  AST_GO: assert property (wr_ctrl && pwdata_i[7:0] == 8'h41 |=> !halt_o && sys_reset_o)
    else $error("reset and run not taken");
  AST_RUN: assert property (wr_ctrl && pwdata_i[7:0] == 8'h40 && halt_o && !brk_i |=> !halt_o && !sys_reset_o)
    else $error("run did not resume cleanly");
  AST_BRK_ON: assert property (brk_i && brk_en_r && !halt_o && !sys_reset_o |=> halt_o)
    else $error("breakpoint did not halt");
  AST_BRK_OFF: assert property (brk_i && !brk_en_r && !halt_o && !wr_ctrl |=> !halt_o)
    else $error("disabled breakpoint halted");
  cover property (stuff_o && stuff_fetch_o == 3'h4);
  cover property (exec_o && exec_len_o == 3'h5);
  cover property ($rose(sys_reset_o) && halt_o);
endmodule

bind dcsc_top dcsc_checker chk_u (.*);

// [bench/dcsc_host.sv]
// host side model of the serial debug link at byte level
module dcsc_host (
  // clock
  input wire logic clk_i,
  // bytes to the block
  output logic rx_valid_o,
  output logic [7:0] rx_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'hA5;
  end
  // one byte per cycle, so a command and its opcode go back to back
  task automatic send(input logic [7:0] b);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= b;
  endtask
  // released data is flipped so a stale byte is never mistaken for a new one
  task automatic idle;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
  endtask
  // command, then the first n bytes of b, low byte first
  task automatic instr(input logic [7:0] cmd, input logic [39:0] b, input int n);
    send(cmd);
    for (int i = 0; i < n; i++) send(b[8*i +: 8]);
    idle();
  endtask
endmodule

// [bench/tb_top.sv]
// self-checking bench for the debug step and control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, read_protect_i = 0, brk_i = 0, done_i = 0;
  logic [7:0] paddr_i = 8'h00, rx_data_i, stuff_opcode_o;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [3:0] pstrb_i = 4'hF;
  logic rx_valid_i, pready_o, pslverr_o, halt_o, sys_reset_o, stuff_o, exec_o, err;
  logic [2:0] stuff_fetch_o, exec_len_o, n;
  logic [39:0] exec_bytes_o, exp_b, mask;
  int miscompares = 0, n_checks = 0, n_stuff = 0, n_exec = 0, n_rst = 0, k;
  // rows: opcode, then instruction length in the low bits
  logic [11:0] rows [8] = '{12'h001, 12'h022, 12'h043, 12'h084, 12'h0A2, 12'h0D3, 12'h0E1, 12'h1F5};
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    n_stuff += (stuff_o === 1'b1);
    n_exec += (exec_o === 1'b1);
    n_rst += (sys_reset_o === 1'b1);
  end
  dcsc_top uut (.*);
  dcsc_host host (.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i));
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // apb master: holds the request until pready is seen at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    // no local limit: the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    #1;
  endtask
  task automatic pulse(input logic breakpoint_instruction);
    @(posedge clk_i);
    if (breakpoint_instruction) brk_i <= 1;
    else done_i <= 1;
    @(posedge clk_i);
    brk_i <= 0;
    done_i <= 0;
    #1;
  endtask
  task automatic close_out;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1;
    #1;
    chk({halt_o, sys_reset_o, stuff_o, exec_o}, 0);
    host.instr(8'h11, 40'h02, 1);
    repeat (3) @(posedge clk_i);
    chk(n_stuff, 0);
    apb(8'h00, 1, 32'h41);
    repeat (6) @(posedge clk_i);
    chk({halt_o, n_rst[7:0]}, 9'h004);
    pulse(1);
    chk(halt_o, 1);
    // ****************************************
    // exec and stuff of every length
    // ****************************************
    foreach (rows[i]) begin
      n = rows[i][2:0];
      exp_b = 40'h0;
      for (k = 0; k < n; k++) exp_b[8*k +: 8] = (k == 0) ? rows[i][11:4] : 8'hA0 + k[7:0];
      mask = (40'h1 << (8 * n)) - 40'h1;
      host.instr(8'h12, exp_b, n);
      #1;
      chk({exec_o, exec_len_o}, {1'b1, n});
      chk(exec_bytes_o & mask, exp_b);
      pulse(0);
      host.instr(8'h11, exp_b, 1);
      #1;
      chk({stuff_o, stuff_opcode_o, stuff_fetch_o}, {1'b1, rows[i][11:4], n - 3'h1});
      pulse(0);
    end
    // clear both sticky flags, then refused commands under read protection and a clean stuff
    apb(8'h04, 1, 32'h30);
    apb(8'h04, 0, 32'h0);
    chk(rd, 32'h03);
    k = n_exec;
    @(posedge clk_i);
    read_protect_i <= 1;
    host.instr(8'h11, 40'h02, 1);
    host.instr(8'h12, 40'h12, 1);
    read_protect_i <= 0;
    host.instr(8'h11, 40'h02, 1);
    #1;
    chk({stuff_o, stuff_opcode_o}, 9'h102);
    chk(n_exec - k, 0);
    pulse(0);
    apb(8'h04, 0, 32'h0);
    chk(rd, 32'h13);
    k = n_rst;
    apb(8'h00, 1, 32'h40);
    repeat (6) @(posedge clk_i);
    chk({halt_o, 8'(n_rst - k)}, 9'h000);
    apb(8'h00, 1, 32'h00);
    pulse(1);
    chk(halt_o, 0);
    apb(8'h00, 1, 32'h81);
    repeat (6) @(posedge clk_i);
    chk({halt_o, 8'(n_rst - k)}, 9'h104);
    apb(8'h00, 0, 32'h0);
    chk(rd, 32'h80);
    apb(8'h10, 0, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    // reset again in mid-run while halted: control state returns to its reset values
    @(posedge clk_i);
    nrst_i <= 0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1;
    #1;
    chk({halt_o, sys_reset_o, stuff_o, exec_o}, 0);
    apb(8'h04, 0, 32'h0);
    chk(rd, 32'h0);
    close_out();
  end
endmodule

// [verilog/dcsc_defines.vh]
// constants for the debug command step and control block
`ifndef DCSC_DEFINES_VH
`define DCSC_DEFINES_VH

// ****************************************
// register map (byte addresses)
// ****************************************
`define DCSC_ADDR_W 8
`define DCSC_REG_CTRL 8'h00
`define DCSC_REG_STAT 8'h04

// ****************************************
// control register fields and reset
// ****************************************
`define DCSC_CTRL_DBG 7
`define DCSC_CTRL_BRKEN 6
`define DCSC_CTRL_RST 0
`define DCSC_CTRL_RESET 8'h00

// ****************************************
// status register fields
// ****************************************
`define DCSC_STAT_DBG 0
`define DCSC_STAT_BRKEN 1
`define DCSC_STAT_BUSY 2
`define DCSC_STAT_RDP 3
`define DCSC_STAT_IGN 4
`define DCSC_STAT_BRKHIT 5

// ****************************************
// host command codes and opcodes
// ****************************************
`define DCSC_CMD_STUFF 8'h11
`define DCSC_CMD_EXEC 8'h12
`define DCSC_OPC_BRK 8'h00
`define DCSC_OPC_PREFIX 8'h1F

// ****************************************
// timing
// ****************************************
// 32 ns reset pulse at an 8 ns clock, sized for the pulse counter
`define DCSC_SYSRST_CYC 8'h04

`endif

// [verilog/dcsc_oplen.v]
// opcode to instruction length decoder
`include "dcsc_defines.vh"

module dcsc_oplen (
  // opcode in
  input wire [7:0] opcode_i,
  // length out, 1..5 bytes
  output reg [2:0] len_o
);

  // ****************************************
  // column based length table
  // ****************************************
  always @* begin
    case (opcode_i[3:0])
      4'h0, 4'h1, 4'h2, 4'h3: len_o = 3'h2;
      4'h4, 4'h5, 4'h6, 4'h7: len_o = 3'h3;
      4'h8, 4'h9: len_o = 3'h4;
      4'hA, 4'hB, 4'hC: len_o = 3'h2;
      4'hD: len_o = 3'h3;
      default: len_o = 3'h1;
    endcase
    // breakpoint opcode is a single byte
    if (opcode_i == `DCSC_OPC_BRK) begin
      len_o = 3'h1;
    end
    // prefixed opcodes carry the longest form
    if (opcode_i == `DCSC_OPC_PREFIX) begin
      len_o = 3'h5;
    end
  end

endmodule

// [verilog/dcsc_rstgen.v]
// system reset pulse generator
`include "dcsc_defines.vh"

module dcsc_rstgen (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // request
  input wire start_i,
  // reset pulse
  output reg sys_reset_o
);

  reg [7:0] cnt_r;

  // ****************************************
  // pulse counter
  // ****************************************
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_r <= 8'h00;
      sys_reset_o <= 1'b0;
    end else if (start_i) begin
      // a new request restarts the full pulse
      cnt_r <= `DCSC_SYSRST_CYC;
      sys_reset_o <= 1'b1;
    end else if (cnt_r > 8'h01) begin
      cnt_r <= cnt_r - 8'h01;
    end else begin
      cnt_r <= 8'h00;
      sys_reset_o <= 1'b0;
    end
  end

endmodule

// [verilog/dcsc_top.v]
// debug command step/execute and debug control register
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`include "dcsc_defines.vh"

// Notes on behaviour
// [RL1] a stuff command single-steps one instruction whose first byte comes from the host.
// [RL2] the remaining zero to four bytes of a stuffed instruction come from program memory.
// [RL3] the stuff command is ignored outside debug state or under read protection.
// [RL4] an execute command takes a whole one to five byte instruction from the host and runs it.
// [RL5] the host sends as many bytes as the opcode needs and the unit counts them by decoding the opcode.
// [RL6] outside debug state or under read protection the execute command eats one byte and runs nothing.
// [RL7] execute can step past a breakpoint by running the original instruction instead.
// [RL8] the control register enters and leaves debug state and gates breakpoints.
// [RL9] writing the reset-and-halt value resets the device and leaves it halted in debug state.
// [RL10] writing the reset-and-run value resets the device and lets the core run.
// [RL11] in debug state writing the run value leaves debug state with no reset.
// [RL12] the host sends the stuff code and then the opcode byte back to back.
// [RL13] a decoded breakpoint with breakpoints enabled enters debug state and idles the core.
// [RL14] with breakpoints disabled the breakpoint signal from the core is disregarded.
module dcsc_top (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // host bytes from the serial framer
  input wire rx_valid_i,
  input wire [7:0] rx_data_i,
  // flash option
  input wire read_protect_i,
  // core side
  input wire brk_i,
  input wire done_i,
  output wire halt_o,
  output wire sys_reset_o,
  output reg stuff_o,
  output reg [7:0] stuff_opcode_o,
  output reg [2:0] stuff_fetch_o,
  output reg exec_o,
  output reg [2:0] exec_len_o,
  output wire [39:0] exec_bytes_o
);

  // ****************************************
  // command states
  // ****************************************
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_STUFF = 3'h1;
  localparam [2:0] S_EXOP = 3'h2;
  localparam [2:0] S_EXBYTE = 3'h3;
  localparam [2:0] S_DISCARD = 3'h4;
  localparam [2:0] S_RUN = 3'h5;
  // reset image of the control register, bits picked per field
  localparam [7:0] CTRL_INIT = `DCSC_CTRL_RESET;

  // ****************************************
  // declarations
  // ****************************************
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg debug_r;
  reg debug_nxt;
  reg brk_en_r;
  reg brk_en_nxt;
  reg ign_r;
  reg ign_nxt;
  reg brk_hit_r;
  reg brk_hit_nxt;
  reg [7:0] ibuf_r [0:4];
  reg [2:0] idx_r;
  reg [2:0] idx_nxt;
  reg [2:0] len_r;
  reg [2:0] len_nxt;
  reg rst_start;
  reg [31:0] rdata;
  reg addr_ok;
  wire [2:0] rx_len;
  wire acc;
  wire wr_ctrl;
  wire wr_stat;
  wire allowed;
  wire brk_take;

  // ****************************************
  // helpers
  // ****************************************
  function is_reg;
    input [7:0] a;
    begin
      is_reg = (a == `DCSC_REG_CTRL) || (a == `DCSC_REG_STAT);
    end
  endfunction

  function [2:0] after_first;
    input [2:0] len;
    begin
      after_first = len - 3'h1;
    end
  endfunction

  // ****************************************
  // opcode length and reset pulse
  // ****************************************
  dcsc_oplen u_oplen (
    .opcode_i(rx_data_i),
    .len_o(rx_len)
  );

  dcsc_rstgen u_rstgen (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(rst_start),
    .sys_reset_o(sys_reset_o)
  );

  // ****************************************
  // apb decode
  // ****************************************
  // writes land on the edge where pready is seen high
  assign acc = psel_i && penable_i && pready_o;
  assign wr_ctrl = acc && pwrite_i && pstrb_i[0] && (paddr_i == `DCSC_REG_CTRL);
  assign wr_stat = acc && pwrite_i && pstrb_i[0] && (paddr_i == `DCSC_REG_STAT);

  always @* begin
    addr_ok = is_reg(paddr_i);
    rdata = 32'h0000_0000;
    if (paddr_i == `DCSC_REG_CTRL) begin
      rdata[`DCSC_CTRL_DBG] = debug_r;
      rdata[`DCSC_CTRL_BRKEN] = brk_en_r;
    end else if (paddr_i == `DCSC_REG_STAT) begin
      rdata[`DCSC_STAT_DBG] = debug_r;
      rdata[`DCSC_STAT_BRKEN] = brk_en_r;
      rdata[`DCSC_STAT_BUSY] = (state_r != S_IDLE);
      rdata[`DCSC_STAT_RDP] = read_protect_i;
      rdata[`DCSC_STAT_IGN] = ign_r;
      rdata[`DCSC_STAT_BRKHIT] = brk_hit_r;
    end
  end

  // one wait state: pready rises in the second access cycle
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && penable_i && !pready_o) begin
      pready_o <= 1'b1;
      pslverr_o <= !addr_ok;
      prdata_o <= pwrite_i ? 32'h0000_0000 : rdata;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // ****************************************
  // debug state and breakpoint control
  // ****************************************
  // breakpoints only count while running and outside a reset pulse
  assign brk_take = brk_i && brk_en_r && !debug_r && !sys_reset_o; // [RL13] [RL14]
  assign halt_o = debug_r; // [RL13]

  always @* begin
    debug_nxt = debug_r;
    brk_en_nxt = brk_en_r;
    brk_hit_nxt = brk_hit_r;
    rst_start = 1'b0;
    if (wr_ctrl) begin
      brk_en_nxt = pwdata_i[`DCSC_CTRL_BRKEN]; // [RL8]
      if (pwdata_i[`DCSC_CTRL_RST]) begin
        rst_start = 1'b1; // [RL9] [RL10]
        debug_nxt = pwdata_i[`DCSC_CTRL_DBG]; // [RL9] [RL10]
      end else begin
        debug_nxt = pwdata_i[`DCSC_CTRL_DBG]; // [RL8] [RL11]
      end
    end
    if (wr_stat && pwdata_i[`DCSC_STAT_BRKHIT]) begin
      brk_hit_nxt = 1'b0;
    end
    // a breakpoint in the same cycle as a write still halts
    if (brk_take) begin
      debug_nxt = 1'b1; // [RL13]
      brk_hit_nxt = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      debug_r <= CTRL_INIT[`DCSC_CTRL_DBG];
      brk_en_r <= CTRL_INIT[`DCSC_CTRL_BRKEN];
      brk_hit_r <= 1'b0;
    end else begin
      debug_r <= debug_nxt;
      brk_en_r <= brk_en_nxt;
      brk_hit_r <= brk_hit_nxt;
    end
  end

  // ****************************************
  // host command sequencer
  // ****************************************
  assign allowed = debug_r && !read_protect_i; // [RL3] [RL6]

  always @* begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    len_nxt = len_r;
    ign_nxt = ign_r;
    if (wr_stat && pwdata_i[`DCSC_STAT_IGN]) begin
      ign_nxt = 1'b0;
    end
    case (state_r)
      S_IDLE: begin
        if (rx_valid_i && rx_data_i == `DCSC_CMD_STUFF) begin
          if (allowed) begin
            state_nxt = S_STUFF; // [RL1] [RL12]
          end else begin
            ign_nxt = 1'b1; // [RL3]
          end
        end else if (rx_valid_i && rx_data_i == `DCSC_CMD_EXEC) begin
          if (allowed) begin
            state_nxt = S_EXOP; // [RL4]
          end else begin
            state_nxt = S_DISCARD; // [RL6]
            ign_nxt = 1'b1;
          end
        end
      end
      S_STUFF: begin
        if (rx_valid_i) begin
          state_nxt = S_RUN; // [RL1]
        end
      end
      S_EXOP: begin
        if (rx_valid_i) begin
          len_nxt = rx_len; // [RL5]
          idx_nxt = 3'h1;
          state_nxt = (rx_len == 3'h1) ? S_RUN : S_EXBYTE;
        end
      end
      S_EXBYTE: begin
        if (rx_valid_i) begin
          idx_nxt = idx_r + 3'h1;
          if (idx_r + 3'h1 == len_r) begin
            state_nxt = S_RUN; // [RL4] [RL5]
          end
        end
      end
      S_DISCARD: begin
        if (rx_valid_i) begin
          state_nxt = S_IDLE; // [RL6]
        end
      end
      S_RUN: begin
        if (done_i) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
    // a device reset drops any command in flight
    if (sys_reset_o) begin
      state_nxt = S_IDLE;
    end
    if (ign_nxt == 1'b0 && ign_r && state_r == S_IDLE && rx_valid_i && !allowed &&
        (rx_data_i == `DCSC_CMD_STUFF || rx_data_i == `DCSC_CMD_EXEC)) begin
      ign_nxt = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      state_r <= S_IDLE;
      idx_r <= 3'h0;
      len_r <= 3'h1;
      ign_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      len_r <= len_nxt;
      ign_r <= ign_nxt;
    end
  end

  // ****************************************
  // instruction byte buffer
  // ****************************************
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      ibuf_r[0] <= 8'h00;
      ibuf_r[1] <= 8'h00;
      ibuf_r[2] <= 8'h00;
      ibuf_r[3] <= 8'h00;
      ibuf_r[4] <= 8'h00;
    end else if (rx_valid_i && state_r == S_EXOP) begin
      ibuf_r[0] <= rx_data_i; // [RL7]
    end else if (rx_valid_i && state_r == S_EXBYTE) begin
      ibuf_r[idx_r] <= rx_data_i; // [RL4]
    end
  end

  assign exec_bytes_o = {ibuf_r[4], ibuf_r[3], ibuf_r[2], ibuf_r[1], ibuf_r[0]};

  // ****************************************
  // core requests
  // ****************************************
  // one-cycle pulses; the core finishes with done_i
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      stuff_o <= 1'b0;
      stuff_opcode_o <= 8'h00;
      stuff_fetch_o <= 3'h0;
      exec_o <= 1'b0;
      exec_len_o <= 3'h0;
    end else begin
      stuff_o <= 1'b0;
      exec_o <= 1'b0;
      if (!sys_reset_o && state_r == S_STUFF && rx_valid_i) begin
        stuff_o <= 1'b1; // [RL1]
        stuff_opcode_o <= rx_data_i; // [RL1]
        stuff_fetch_o <= after_first(rx_len); // [RL2]
      end
      if (!sys_reset_o && state_r == S_EXOP && rx_valid_i && rx_len == 3'h1) begin
        exec_o <= 1'b1; // [RL4] [RL7]
        exec_len_o <= rx_len;
      end
      if (!sys_reset_o && state_r == S_EXBYTE && rx_valid_i && idx_r + 3'h1 == len_r) begin
        exec_o <= 1'b1; // [RL4]
        exec_len_o <= len_r; // [RL5]
      end
    end
  end

endmodule

// [verilog/dcsc_top_unused_note_removed.v]
// no logic here: the block's modules live in the other design files
